// file: verilog/coproc_decoder_cfg.svh
// register map, field positions and reset values of the co-processor instruction decoder
// Notes on behaviour
// - each instruction gets exactly one of five classes, or none when unrecognised.
// - data op is bits 27:24 = 1110 with bit 4 clear; fields by position.
// - load is bits 27:25 = 110 with bit 20 set; fields by position.
// - store has the load layout but bit 20 clear.
// - core-to-coproc move writes the core value into the selected coproc register.
// - coproc-to-core move reads the selected coproc register out to the core.
// - bits 31:28 hold the condition that gates execution.
// - codes 0000-0111 test zero, carry, negative, overflow set or clear.
// - 1000 is carry and not zero; 1001 is not carry or zero.
// - 1010 passes when negative equals overflow; 1011 when they differ.
// - 1100 is not zero and n equals v; 1101 is zero or n differs.
// - primary and secondary opcodes are passed on uninterpreted.
// - the core base register field is ignored here.
// - core_transfer_reg names the core register of a move.
// - wide_data gives the data width of a load or store.
// - wide flag 0 is 32-bit data, 1 is 64-bit data.
// - the writeback flag is ignored here.
// - the 8-bit offset field is ignored here.
`ifndef COPROC_DECODER_CFG_SVH
`define COPROC_DECODER_CFG_SVH

`define OFS_INSTR       8'h00
`define OFS_FLAGS       8'h04
`define OFS_STATUS      8'h08
`define OFS_FIELDS      8'h0C
`define OFS_XFER_IN     8'h10
`define OFS_XFER_OUT    8'h14

`define RST_WORD        32'h0000_0000
`define RST_FLAGS       4'h0
`define RST_NIB         4'h0

`define FLAG_Z          0
`define FLAG_C          1
`define FLAG_N          2
`define FLAG_V          3

`define COND_HI         31
`define COND_LO         28
`define FMT4_HI         27
`define FMT4_LO         24
`define FMT3_LO         25
`define FMT_REGOP       4'hE
`define FMT_MEM         3'h6
`define DIR_BIT         20
`define KIND_BIT        4
`define WIDE_BIT        22
`define OP1_HI          23
`define OP1_LO          20
`define SRCA_HI         19
`define SRCA_LO         16
`define DEST_HI         15
`define DEST_LO         12
`define CPNUM_HI        11
`define CPNUM_LO        8
`define OP2_HI          7
`define OP2_LO          5
`define SRCB_HI         3
`define SRCB_LO         0

`define CC_EQ           4'h0
`define CC_NE           4'h1
`define CC_CS           4'h2
`define CC_CC           4'h3
`define CC_MI           4'h4
`define CC_PL           4'h5
`define CC_VS           4'h6
`define CC_VC           4'h7
`define CC_HI           4'h8
`define CC_LS           4'h9
`define CC_GE           4'hA
`define CC_LT           4'hB
`define CC_GT           4'hC
`define CC_LE           4'hD
`define CC_AL           4'hE
`define CC_NV           4'hF

`endif

// file: verilog/coproc_decoder_pkg.sv
// types shared by the co-processor instruction decoder
`default_nettype none
package coproc_decoder_pkg;
  typedef enum logic [4:0] {
    CLS_NONE  = 5'b00000,
    CLS_DATA  = 5'b00001,
    CLS_LOAD  = 5'b00010,
    CLS_STORE = 5'b00100,
    CLS_C2CP  = 5'b01000,
    CLS_CP2C  = 5'b10000
  } instr_class_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DECODE = 3'b010,
    ST_READ   = 3'b100
  } dec_state_t;
endpackage : coproc_decoder_pkg
`default_nettype wire

// file: verilog/coproc_reg_mem.sv
// co-processor register file with registered read data
`timescale 1ns/1ps
`default_nettype none
module coproc_reg_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock
  input  wire logic             pclk,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read port
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array: contents are undefined until written
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : coproc_reg_mem
`default_nettype wire

// file: verilog/coproc_instr_decoder.sv
// co-processor instruction decoder with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "coproc_decoder_cfg.svh"
module coproc_instr_decoder #(
  parameter int AW    = 8,
  parameter int NREGS = 16
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // decode result
  output logic      [4:0]    instr_class,
  output logic               cond_pass,
  output logic      [3:0]    core_transfer_reg,
  output logic               wide_data
);
  coproc_decoder_pkg::dec_state_t   state_q;
  coproc_decoder_pkg::instr_class_t cls_d;
  coproc_decoder_pkg::instr_class_t cls_q;
  logic [31:0] instr_q;
  logic [3:0]  flags_q;
  logic [31:0] xfer_in_q;
  logic [31:0] xfer_out_q;
  logic [31:0] mem_rdata;
  logic [31:0] rd_mux;
  logic        pass_d;
  logic        pass_q;
  logic        unrec_q;
  logic        wide_q;
  logic        done_q;
  logic [3:0]  op1_q;
  logic [2:0]  op2_q;
  logic [3:0]  srca_q;
  logic [3:0]  dest_q;
  logic [3:0]  cpnum_q;
  logic [3:0]  srcb_q;
  logic [3:0]  core_reg_q;
  logic        acc_first;
  logic        take;
  logic        wr_take;
  logic        mem_we;
  logic        mem_re;
  logic        busy;

  // true when the address names a mapped register
  function automatic logic addr_hit(input logic [AW-1:0] a);
    addr_hit = (a == `OFS_INSTR) || (a == `OFS_FLAGS) || (a == `OFS_STATUS) ||
               (a == `OFS_FIELDS) || (a == `OFS_XFER_IN) || (a == `OFS_XFER_OUT);
  endfunction : addr_hit

  // condition evaluation against z, c, n, v
  function automatic logic cond_eval(input logic [3:0] cc, input logic [3:0] f);
    logic z;
    logic c;
    logic n;
    logic v;
    z = f[`FLAG_Z];
    c = f[`FLAG_C];
    n = f[`FLAG_N];
    v = f[`FLAG_V];
    case (cc)
      `CC_EQ:  cond_eval = z;
      `CC_NE:  cond_eval = !z;
      `CC_CS:  cond_eval = c;
      `CC_CC:  cond_eval = !c;
      `CC_MI:  cond_eval = n;
      `CC_PL:  cond_eval = !n;
      `CC_VS:  cond_eval = v;
      `CC_VC:  cond_eval = !v;
      `CC_HI:  cond_eval = c && !z;
      `CC_LS:  cond_eval = !c || z;
      `CC_GE:  cond_eval = (n == v);
      `CC_LT:  cond_eval = (n != v);
      `CC_GT:  cond_eval = !z && (n == v);
      `CC_LE:  cond_eval = z || (n != v);
      `CC_AL:  cond_eval = 1'b1;
      default: cond_eval = 1'b0;                   // never
    endcase
  endfunction : cond_eval

  assign busy      = (state_q != coproc_decoder_pkg::ST_IDLE);
  assign acc_first = psel && penable && !pready;
  assign take      = psel && penable && pready;
  assign wr_take   = take && pwrite && !pslverr;

  // class decode; base reg, p, u, w and offset bits are never looked at
  always_comb begin
    cls_d = coproc_decoder_pkg::CLS_NONE;
    if (instr_q[`FMT4_HI:`FMT4_LO] == `FMT_REGOP) begin
      if (instr_q[`KIND_BIT]) begin
        cls_d = instr_q[`DIR_BIT] ? coproc_decoder_pkg::CLS_CP2C : coproc_decoder_pkg::CLS_C2CP;
      end else begin
        cls_d = coproc_decoder_pkg::CLS_DATA;
      end
    end else if (instr_q[`FMT4_HI:`FMT3_LO] == `FMT_MEM) begin
      cls_d = instr_q[`DIR_BIT] ? coproc_decoder_pkg::CLS_LOAD : coproc_decoder_pkg::CLS_STORE;
    end
  end

  assign pass_d = cond_eval(instr_q[`COND_HI:`COND_LO], flags_q);

  // register moves only happen when the condition passes
  assign mem_we = (state_q == coproc_decoder_pkg::ST_DECODE) && pass_d &&
                  (cls_d == coproc_decoder_pkg::CLS_C2CP);
  assign mem_re = (state_q == coproc_decoder_pkg::ST_DECODE) && pass_d &&
                  (cls_d == coproc_decoder_pkg::CLS_CP2C);

  coproc_reg_mem #(
    .WIDTH (32),
    .DEPTH (NREGS),
    .AW    (4)
  ) u_regs (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (instr_q[`SRCA_HI:`SRCA_LO]),
    .wdata (xfer_in_q),
    .re    (mem_re),
    .raddr (instr_q[`SRCA_HI:`SRCA_LO]),
    .rdata (mem_rdata)
  );

  // sequencer: a write to the instruction register starts one decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= coproc_decoder_pkg::ST_IDLE;
    end else begin
      case (state_q)
        coproc_decoder_pkg::ST_IDLE: begin
          if (wr_take && paddr == `OFS_INSTR) begin
            state_q <= coproc_decoder_pkg::ST_DECODE;
          end
        end
        coproc_decoder_pkg::ST_DECODE: begin
          state_q <= mem_re ? coproc_decoder_pkg::ST_READ : coproc_decoder_pkg::ST_IDLE;
        end
        coproc_decoder_pkg::ST_READ: begin
          state_q <= coproc_decoder_pkg::ST_IDLE;
        end
        default: begin
          state_q <= coproc_decoder_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q   <= `RST_WORD;
      flags_q   <= `RST_FLAGS;
      xfer_in_q <= `RST_WORD;
    end else if (wr_take) begin
      if (paddr == `OFS_INSTR) begin
        instr_q <= pwdata;
      end
      if (paddr == `OFS_FLAGS) begin
        flags_q <= pwdata[3:0];
      end
      if (paddr == `OFS_XFER_IN) begin
        xfer_in_q <= pwdata;
      end
    end
  end

  // decode results are latched once per instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cls_q      <= coproc_decoder_pkg::CLS_NONE;
      pass_q     <= 1'b0;
      unrec_q    <= 1'b0;
      wide_q     <= 1'b0;
      op1_q      <= `RST_NIB;
      op2_q      <= 3'h0;
      srca_q     <= `RST_NIB;
      dest_q     <= `RST_NIB;
      cpnum_q    <= `RST_NIB;
      srcb_q     <= `RST_NIB;
      core_reg_q <= `RST_NIB;
    end else if (state_q == coproc_decoder_pkg::ST_DECODE) begin
      cls_q   <= cls_d;
      pass_q  <= pass_d;
      unrec_q <= (cls_d == coproc_decoder_pkg::CLS_NONE);
      // 0 is 32-bit data, 1 is 64-bit data; only meaningful for load and store
      wide_q  <= ((cls_d == coproc_decoder_pkg::CLS_LOAD) || (cls_d == coproc_decoder_pkg::CLS_STORE)) &&
                 instr_q[`WIDE_BIT];
      // opcodes are handed on raw; their meaning belongs to the operation map
      op1_q   <= instr_q[`OP1_HI:`OP1_LO];
      op2_q   <= instr_q[`OP2_HI:`OP2_LO];
      srca_q  <= instr_q[`SRCA_HI:`SRCA_LO];
      dest_q  <= instr_q[`DEST_HI:`DEST_LO];
      cpnum_q <= instr_q[`CPNUM_HI:`CPNUM_LO];
      srcb_q  <= instr_q[`SRCB_HI:`SRCB_LO];
      if ((cls_d == coproc_decoder_pkg::CLS_C2CP) || (cls_d == coproc_decoder_pkg::CLS_CP2C)) begin
        core_reg_q <= instr_q[`DEST_HI:`DEST_LO];
      end
    end
  end

  // move result toward the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_out_q <= `RST_WORD;
    end else if (state_q == coproc_decoder_pkg::ST_READ) begin
      xfer_out_q <= mem_rdata;
    end
  end

  // done flag: hardware set wins over the clear by a new instruction write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (state_q == coproc_decoder_pkg::ST_DECODE && !mem_re) begin
      done_q <= 1'b1;
    end else if (state_q == coproc_decoder_pkg::ST_READ) begin
      done_q <= 1'b1;
    end else if (wr_take && paddr == `OFS_INSTR) begin
      done_q <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = `RST_WORD;
    case (paddr)
      `OFS_INSTR:    rd_mux = instr_q;
      `OFS_FLAGS:    rd_mux = {28'h000_0000, flags_q};
      `OFS_STATUS:   rd_mux = {19'h0_0000, done_q, wide_q, unrec_q, busy, pass_q, 3'h0, cls_q};
      `OFS_FIELDS:   rd_mux = {8'h00, srcb_q, cpnum_q, dest_q, srca_q, 1'b0, op2_q, op1_q};
      `OFS_XFER_IN:  rd_mux = xfer_in_q;
      `OFS_XFER_OUT: rd_mux = xfer_out_q;
      default:       rd_mux = `RST_WORD;
    endcase
  end

  // apb: one wait cycle, so every answer leaves a flop; an instruction write while busy is refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first && (!addr_hit(paddr) || (pwrite && paddr == `OFS_INSTR && busy));
      if (acc_first && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // decode outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_class       <= 5'h00;
      cond_pass         <= 1'b0;
      core_transfer_reg <= `RST_NIB;
      wide_data         <= 1'b0;
    end else begin
      instr_class       <= cls_q;
      cond_pass         <= pass_q;
      core_transfer_reg <= core_reg_q;
      wide_data         <= wide_q;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_decode;
    state_q == coproc_decoder_pkg::ST_DECODE;
  endsequence
  sequence s_read_issue;
    s_decode ##0 mem_re;
  endsequence

  a_class_onehot:   assert property (s_decode |=> $onehot0(cls_q) ##1 instr_class == $past(cls_q))
    else $error("class not one-hot or not forwarded");
  a_data_op_fmt:    assert property (s_decode ##0 (instr_q[27:24] == 4'hE && !instr_q[4])
                      |=> cls_q == coproc_decoder_pkg::CLS_DATA)
    else $error("data op not recognised");
  a_load_fmt:       assert property (s_decode ##0 (instr_q[27:25] == 3'h6 && instr_q[20])
                      |=> cls_q == coproc_decoder_pkg::CLS_LOAD)
    else $error("load not recognised");
  a_store_fmt:      assert property (s_decode ##0 (instr_q[27:25] == 3'h6 && !instr_q[20])
                      |=> cls_q == coproc_decoder_pkg::CLS_STORE)
    else $error("store not recognised");
  a_move_write:     assert property (mem_we |-> cls_d == coproc_decoder_pkg::CLS_C2CP && pass_d &&
                      instr_q[4] && !instr_q[20])
    else $error("register write without a passing move");
  a_move_read:      assert property (s_read_issue |=> state_q == coproc_decoder_pkg::ST_READ
                      ##1 (xfer_out_q == $past(mem_rdata) && !busy && done_q))
    else $error("move result not delivered in two cycles");
  a_cond_always:    assert property (s_decode ##0 instr_q[31:28] == 4'hE |=> pass_q)
    else $error("always condition failed");
  a_cond_never:     assert property (s_decode ##0 instr_q[31:28] == 4'hF |=> !pass_q ##1 !cond_pass)
    else $error("never condition passed");
  a_cond_zero:      assert property (s_decode ##0 instr_q[31:28] == 4'h0 |=> pass_q == $past(flags_q[0]))
    else $error("equal condition wrong");
  a_cond_higher:    assert property (s_decode ##0 instr_q[31:28] == 4'h8
                      |=> pass_q == ($past(flags_q[1]) && !$past(flags_q[0])))
    else $error("higher condition wrong");
  a_cond_ge:        assert property (s_decode ##0 instr_q[31:28] == 4'hA
                      |=> pass_q == ($past(flags_q[2]) == $past(flags_q[3])))
    else $error("signed ge condition wrong");
  a_cond_gt:        assert property (s_decode ##0 instr_q[31:28] == 4'hC
                      |=> pass_q == (!$past(flags_q[0]) && $past(flags_q[2]) == $past(flags_q[3])))
    else $error("signed gt condition wrong");
  a_wide_flag:      assert property (s_decode ##0 instr_q[27:25] == 3'h6 |=> wide_q == $past(instr_q[22])
                      ##1 wide_data == $past(wide_q))
    else $error("wide flag not carried");
  a_core_reg:       assert property (s_decode ##0 instr_q[27:24] == 4'hE && instr_q[4]
                      |=> core_reg_q == $past(instr_q[15:12]))
    else $error("core transfer register wrong");
endmodule : coproc_instr_decoder
`default_nettype wire

// file: tb/host_core_model.sv
// apb-side model of the host core that issues co-processor instructions
`timescale 1ns/1ps
`default_nettype none
module host_core_model (
  // clock
  input  wire logic        pclk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // one transfer; released lines carry the inverse so a stale value never looks valid
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= ~wr;
    paddr   <= ~a;
    pwdata  <= ~wd;
  endtask : xfer

  // the host owns indexing, offset direction, writeback and base register, so any value is legal here
  function automatic logic [31:0] mem_word(input logic [3:0] cnd, input logic pre, input logic add,
                                           input logic wide, input logic wb, input logic load,
                                           input logic [3:0] base, input logic [3:0] dest,
                                           input logic [3:0] cpn, input logic [7:0] ofs);
    return {cnd, 3'b110, pre, add, wide, wb, load, base, dest, cpn, ofs};
  endfunction : mem_word
endmodule : host_core_model
`default_nettype wire

// file: tb/coproc_instr_decoder_bench.sv
// self-checking bench for the co-processor instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "coproc_decoder_cfg.svh"
module coproc_instr_decoder_bench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  instr_class;
  logic        cond_pass;
  logic [3:0]  core_transfer_reg;
  logic        wide_data;
  int          mismatches;
  int          checked;
  logic [31:0] rd;
  logic        err;

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  coproc_instr_decoder #(.AW(8), .NREGS(16)) u_coproc_instr_decoder (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_class(instr_class), .cond_pass(cond_pass), .core_transfer_reg(core_transfer_reg),
    .wide_data(wide_data));

  host_core_model u_host_core_model (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic results;
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host_core_model.xfer(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    u_host_core_model.xfer(1'b0, a, 32'h0000_0000, rd, err);
  endtask : rdr

  // condition truth worked out independently from the flag nibble {v, n, c, z}
  function automatic logic cond_exp(input logic [3:0] c, input logic [3:0] f);
    logic [15:0] t;
    t = {1'b0, 1'b1, f[0] | (f[2] != f[3]), !f[0] & (f[2] == f[3]), f[2] != f[3], f[2] == f[3],
         !f[1] | f[0], f[1] & !f[0], !f[3], f[3], !f[2], f[2], !f[1], f[1], !f[0], f[0]};
    return t[c];
  endfunction : cond_exp

  function automatic logic [31:0] fld(input logic [31:0] w);
    return {8'h00, w[3:0], w[11:8], w[15:12], w[19:16], 1'b0, w[7:5], w[23:20]};
  endfunction : fld

  // issue one instruction and poll until the decode has settled; rd keeps the status word
  task automatic run_instr(input logic [31:0] w);
    int i;
    wr(`OFS_INSTR, w);
    chk({31'h0, err}, 32'h0000_0000);
    for (i = 0; i < 8; i++) begin
      rdr(`OFS_STATUS);
      if (rd[9] === 1'b0 && rd[12] === 1'b1) break;
    end
    chk({31'h0, rd[12]}, 32'h0000_0001);
  endtask : run_instr

  task automatic t_reset;
    chk({22'h0, instr_class, cond_pass, core_transfer_reg}, 32'h0000_0000);
    rdr(`OFS_STATUS);
    chk(rd, 32'h0000_0000);
    wr(`OFS_FLAGS, 32'h0000_000A);
    rdr(`OFS_FLAGS);
    chk({28'h0, rd[3:0]}, 32'h0000_000A);
  endtask : t_reset

  task automatic t_bus;
    rdr(8'h18);
    chk({rd[30:0], err}, 32'h0000_0001);
    wr(8'h1C, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0000_0001);
  endtask : t_bus

  // data, load, store and unrecognised words, with the bits the decoder must ignore flipped on the repeated load and store
  task automatic t_class;
    logic [31:0] w [7];
    logic [4:0]  k [7];
    logic        wd [7];
    logic [31:0] ex;
    w = '{32'hEE53_A4CC,
          u_host_core_model.mem_word(4'hE, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 4'h2, 4'h7, 4'h5, 8'h3F),
          u_host_core_model.mem_word(4'hE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h2, 4'h7, 4'h5, 8'h3F),
          u_host_core_model.mem_word(4'hE, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 4'h7, 4'h5, 8'hC0),
          u_host_core_model.mem_word(4'hE, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 4'h9, 4'h6, 8'h00),
          32'hEF00_0000, 32'hE000_0010};
    k = '{5'h01, 5'h02, 5'h04, 5'h02, 5'h04, 5'h00, 5'h00};
    wd = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 7; i++) begin
      run_instr(w[i]);
      ex = {19'h0, 1'b1, wd[i], k[i] == 5'h00, 1'b0, 1'b0, 3'h0, k[i]};
      chk(rd & 32'hFFFF_FEFF, ex);
      chk({26'h0, wide_data, instr_class}, {26'h0, wd[i], k[i]});
      if (k[i] != 5'h00) begin
        rdr(`OFS_FIELDS);
        chk(rd, fld(w[i]));
      end
    end
  endtask : t_class

  task automatic t_move;
    wr(`OFS_XFER_IN, 32'h1234_5678);
    run_instr(32'hEE01_9410);
    chk({23'h0, instr_class, core_transfer_reg}, 32'h0000_0089);
    wr(`OFS_XFER_IN, 32'hA5A5_0F0F);
    run_instr(32'hEE03_9410);
    run_instr(32'hEE11_6410);
    chk({23'h0, instr_class, core_transfer_reg}, 32'h0000_0106);
    rdr(`OFS_XFER_OUT);
    chk(rd, 32'h1234_5678);
    // a never-condition read must leave the core-side value alone
    run_instr(32'hFE13_5410);
    chk({31'h0, cond_pass}, 32'h0000_0000);
    rdr(`OFS_XFER_OUT);
    chk(rd, 32'h1234_5678);
    run_instr(32'hEE13_C410);
    chk({28'h0, core_transfer_reg}, 32'h0000_000C);
    rdr(`OFS_XFER_OUT);
    chk(rd, 32'hA5A5_0F0F);
  endtask : t_move

  // a reset in mid-run must clear the decode results and the flag register
  task automatic t_rst_mid;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({22'h0, instr_class, cond_pass, core_transfer_reg}, 32'h0000_0000);
    presetn <= 1'b1;
    rdr(`OFS_STATUS);
    chk(rd, 32'h0000_0000);
    rdr(`OFS_FLAGS);
    chk(rd, 32'h0000_0000);
  endtask : t_rst_mid

  task automatic t_cond;
    for (int c = 0; c < 16; c++) begin
      for (int f = 0; f < 16; f++) begin
        wr(`OFS_FLAGS, {28'h0, f[3:0]});
        run_instr({c[3:0], 28'hE53_A4CC});
        chk({30'h0, cond_pass, rd[8]}, {30'h0, {2{cond_exp(c[3:0], f[3:0])}}});
      end
    end
  endtask : t_cond

  initial begin
    mismatches = 0;
    checked = 0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_bus;
    t_class;
    t_move;
    t_rst_mid;
    t_cond;
    results;
  end

  // roughly 300 instructions of under 25 cycles each fit well inside this span
  initial begin
    #1_000_000;
    mismatches++;
    results;
  end
endmodule : coproc_instr_decoder_bench
`default_nettype wire
